// >>> rsr_core.sv
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// - Microstep rate from velocity and pulse divisor
// - Pulse divisor 0..13, velocity clamped to 2047
// - Full-step pulse every 2^res microsteps, res 0..8
// - Ramp slope from acceleration and ramp divisor
// - Report positioning acceleration window compliance
// - Reference search start, stop by command; query type has no effect
// - End switch auto-stop ignored while searching
// - Search speed until switch first found
// - Calibrate at creep speed, zero at midpoint
// - Mode setting selects eight search sequences
// - Mode 1 left switch, plus 64 right
// - Mode 2 both ends, store switch distance
// - Mode 3 far end, then switch middle
// - Mode 4 middle of one end switch
// - Modes 5,6 home search with reversal
// - Modes 7,8 home search ignoring ends
// - Plus 128 inverts home switch polarity
module rsr_core
  #(
    parameter int VEL_W = 11,
    parameter int POS_W = 32
  )
  (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rstn_i,
    // APB slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [11:0]           paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic                       pready_o,
    output logic [31:0]                prdata_o,
    output logic                       pslverr_o,
    // Switch pins, asynchronous
    input  wire rsr_pkg::rsr_sw_s      sw_i,
    // Step generator side
    output logic                       step_o,
    output logic                       dir_o,
    output logic                       fullstep_o,
    output logic                       busy_o,
    output logic                       irq_o
  );

  function automatic logic [29:0] pow2(input int n);
    pow2 = 30'h00000001 << n;
  endfunction

  function automatic logic [VEL_W-1:0] mag(input logic signed [VEL_W:0] v);
    logic signed [VEL_W:0] a;
    a = (v < 0) ? -v : v;
    mag = a[VEL_W-1:0];
  endfunction

  function automatic logic accel_ok(input logic [3:0] rd, input logic [3:0] pd,
                                    input logic [10:0] a);
    int d;
    int lo;
    int hi;
    d  = int'(rd) - int'(pd);
    lo = (d - 1 < 0) ? 0 : (1 << (d - 1));
    hi = (d + 12 < 0) ? 0 : ((d + 12 >= 11) ? 2047 : (1 << (d + 12)) - 1);
    accel_ok = (int'(a) >= lo) && (int'(a) <= hi);
  endfunction

  // Switch synchronisers; a change counts once stages two and three agree
  rsr_pkg::rsr_sw_s sw_s1_r, sw_s2_r, sw_s3_r, sw_q_r;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      sw_s1_r <= '0;
      sw_s2_r <= '0;
      sw_s3_r <= '0;
      sw_q_r  <= '0;
    end
    else
    begin
      sw_s1_r <= sw_i;
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
      sw_q_r  <= (sw_s2_r & ~(sw_s2_r ^ sw_s3_r)) | (sw_q_r & (sw_s2_r ^ sw_s3_r));
    end
  end

  // Registers
  logic [7:0]              mode_r;
  logic [VEL_W-1:0]        srch_spd_r, cal_spd_r;
  logic [3:0]              pdiv_r, rdiv_r, res_r;
  logic                    stopl_en_r, stopr_en_r;
  logic signed [VEL_W:0]   host_v_r;
  logic [10:0]             accel_r;
  logic [rsr_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r;
  logic [31:0]             cmd_r;
  logic [POS_W-1:0]        pos_r, dist_r;
  logic signed [VEL_W:0]   cur_v_r;
  rsr_pkg::rsr_state_e     state_r;

  // APB: one wait cycle, write and read both complete at the pready edge
  logic pready_r;
  wire  acc_w = psel_i & penable_i & ~pready_r;
  wire  wr_w  = psel_i & penable_i & pready_r & pwrite_i;
  wire  [11:0] a_w = paddr_i;

  wire wr_cmd   = wr_w && (a_w == rsr_pkg::OFF_CMD);
  wire wr_mode  = wr_w && (a_w == rsr_pkg::OFF_MODE);
  wire wr_sspd  = wr_w && (a_w == rsr_pkg::OFF_SRCH_SPD);
  wire wr_cspd  = wr_w && (a_w == rsr_pkg::OFF_CAL_SPD);
  wire wr_div   = wr_w && (a_w == rsr_pkg::OFF_DIVIDERS);
  wire wr_vel   = wr_w && (a_w == rsr_pkg::OFF_VELOCITY);
  wire wr_acc   = wr_w && (a_w == rsr_pkg::OFF_ACCEL);
  wire wr_istat = wr_w && (a_w == rsr_pkg::OFF_IRQ_STAT);
  wire wr_imask = wr_w && (a_w == rsr_pkg::OFF_IRQ_MASK);

  wire [7:0] opc_w   = pwdata_i[7:0];
  wire [1:0] ctype_w = pwdata_i[rsr_pkg::CMD_TYPE_LSB +: 2];
  wire       is_rs_w = (opc_w == rsr_pkg::OPC_REF_SEARCH);
  wire [3:0] wpd_w   = pwdata_i[rsr_pkg::DIV_PULSE_LSB +: 4];
  wire [3:0] wres_w  = pwdata_i[rsr_pkg::DIV_RES_LSB +: 4];
  wire signed [VEL_W:0] wvel_w = pwdata_i[VEL_W:0];

  wire [5:0] base_w     = mode_r[5:0];
  wire       swap_w     = mode_r[6];
  wire       home_inv_w = mode_r[7];
  wire       mode_ok_w  = (base_w >= 6'h01) && (base_w <= 6'h08);
  wire       idle_w     = (state_r == rsr_pkg::RS_IDLE);
  wire       cmd_start  = wr_cmd && is_rs_w && (ctype_w == rsr_pkg::CMD_START);
  wire       cmd_stop   = wr_cmd && is_rs_w && (ctype_w == rsr_pkg::CMD_STOP);
  wire       cmd_bad    = wr_cmd && (!is_rs_w || (ctype_w == 2'h3));
  wire       start_go   = cmd_start && idle_w && mode_ok_w;

  wire       ok_w = accel_ok(rdiv_r, pdiv_r, accel_r);

  logic [31:0] rdata_w;
  logic        rhit_w;
  always_comb
  begin
    rhit_w  = 1'b1;
    rdata_w = 32'h00000000;
    if (a_w == rsr_pkg::OFF_CMD)
      rdata_w = cmd_r;
    else if (a_w == rsr_pkg::OFF_MODE)
      rdata_w[7:0] = mode_r;
    else if (a_w == rsr_pkg::OFF_SRCH_SPD)
      rdata_w[VEL_W-1:0] = srch_spd_r;
    else if (a_w == rsr_pkg::OFF_CAL_SPD)
      rdata_w[VEL_W-1:0] = cal_spd_r;
    else if (a_w == rsr_pkg::OFF_DIVIDERS)
      rdata_w[13:0] = {stopr_en_r, stopl_en_r, res_r, rdiv_r, pdiv_r};
    else if (a_w == rsr_pkg::OFF_VELOCITY)
      rdata_w = 32'(host_v_r);
    else if (a_w == rsr_pkg::OFF_ACCEL)
      rdata_w[10:0] = accel_r;
    else if (a_w == rsr_pkg::OFF_STATUS)
      rdata_w = {4'h0, cur_v_r[VEL_W:0], 8'h00, state_r, sw_q_r, ok_w, dir_o, ~idle_w};
    else if (a_w == rsr_pkg::OFF_POSITION)
      rdata_w = 32'(pos_r);
    else if (a_w == rsr_pkg::OFF_DISTANCE)
      rdata_w = 32'(dist_r);
    else if (a_w == rsr_pkg::OFF_IRQ_STAT)
      rdata_w[rsr_pkg::IRQ_W-1:0] = irq_stat_r;
    else if (a_w == rsr_pkg::OFF_IRQ_MASK)
      rdata_w[rsr_pkg::IRQ_W-1:0] = irq_mask_r;
    else
      rhit_w = 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      pready_r  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_r  <= acc_w;
      prdata_o  <= (acc_w && !pwrite_i && rhit_w) ? rdata_w : 32'h00000000;
      pslverr_o <= acc_w && !rhit_w;
    end
  end
  assign pready_o = pready_r;

  // Configuration registers; out-of-range pulse divisor, resolution and velocity writes clamp to the documented limits
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      cmd_r      <= 32'h00000000;
      mode_r     <= rsr_pkg::MODE_RST;
      srch_spd_r <= rsr_pkg::SRCH_SPD_RST;
      cal_spd_r  <= rsr_pkg::CAL_SPD_RST;
      pdiv_r     <= rsr_pkg::PULSE_DIV_RST;
      rdiv_r     <= rsr_pkg::RAMP_DIV_RST;
      res_r      <= rsr_pkg::USTEP_RES_RST;
      stopl_en_r <= 1'b0;
      stopr_en_r <= 1'b0;
      host_v_r   <= '0;
      accel_r    <= rsr_pkg::ACCEL_RST;
      irq_mask_r <= '0;
    end
    else
    begin
      if (wr_cmd)
        cmd_r <= pwdata_i;
      if (wr_mode)
        mode_r <= pwdata_i[7:0];
      if (wr_sspd)
        srch_spd_r <= pwdata_i[VEL_W-1:0];
      if (wr_cspd)
        cal_spd_r <= pwdata_i[VEL_W-1:0];
      if (wr_div)
      begin
        pdiv_r <= (wpd_w > rsr_pkg::PULSE_DIV_MAX) ? rsr_pkg::PULSE_DIV_MAX : wpd_w;
        rdiv_r <= pwdata_i[rsr_pkg::DIV_RAMP_LSB +: 4];
        res_r  <= (wres_w > rsr_pkg::USTEP_RES_MAX) ? rsr_pkg::USTEP_RES_MAX : wres_w;
        stopl_en_r <= pwdata_i[rsr_pkg::DIV_STOPL_BIT];
        stopr_en_r <= pwdata_i[rsr_pkg::DIV_STOPR_BIT];
      end
      if (wr_vel)
        host_v_r <= (wvel_w[VEL_W] && wvel_w[VEL_W-1:0] == '0) ? {wvel_w[VEL_W:1], 1'b1} : wvel_w;
      if (wr_acc)
        accel_r <= pwdata_i[10:0];
      if (wr_imask)
        irq_mask_r <= pwdata_i[rsr_pkg::IRQ_W-1:0];
    end
  end

  // 16 MHz pulse base as a fractional enable from the 125 MHz clock
  logic [7:0] tick_acc_r;
  logic       tick_r;
  wire  [7:0] tick_sum_w = tick_acc_r + rsr_pkg::TICK_NUM;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      tick_acc_r <= 8'h00;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r     <= (tick_sum_w >= rsr_pkg::TICK_DEN);
      tick_acc_r <= (tick_sum_w >= rsr_pkg::TICK_DEN) ? tick_sum_w - rsr_pkg::TICK_DEN
                                                      : tick_sum_w;
    end
  end

  // Target velocity: search legs override the host velocity and the auto-stop
  logic seek_pos_r, cal_pos_r;
  wire  in_cal_w   = (state_r == rsr_pkg::RS_CAL);
  wire  mv_pos_w   = in_cal_w ? cal_pos_r : seek_pos_r;
  wire  [VEL_W-1:0] spd_w = in_cal_w ? cal_spd_r : srch_spd_r;
  wire  signed [VEL_W:0] srch_v_w = mv_pos_w ? $signed({1'b0, spd_w})
                                             : -$signed({1'b0, spd_w});
  // Auto-stop applies only outside a search
  wire  autostop_w = idle_w && ((stopl_en_r && sw_q_r.left && host_v_r < 0) ||
                                (stopr_en_r && sw_q_r.right && host_v_r > 0));
  wire  signed [VEL_W:0] tgt_v_w = !idle_w ? srch_v_w : (autostop_w ? '0 : host_v_r);

  // Ramp: one internal velocity unit per 2^(ramp_div+13) base ticks per accel unit
  logic [29:0] ramp_acc_r;
  wire  [29:0] ramp_thr_w = pow2(int'(rdiv_r) + rsr_pkg::RAMP_LOG2);
  wire  [29:0] ramp_sum_w = ramp_acc_r + 30'(accel_r);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      ramp_acc_r <= '0;
      cur_v_r    <= '0;
    end
    else if (tick_r)
    begin
      if (cur_v_r == tgt_v_w)
        ramp_acc_r <= '0;
      else if (accel_r == 11'h000)
        cur_v_r <= tgt_v_w;
      else if (ramp_sum_w >= ramp_thr_w)
      begin
        ramp_acc_r <= ramp_sum_w - ramp_thr_w;
        cur_v_r    <= (cur_v_r < tgt_v_w) ? cur_v_r + 1'b1 : cur_v_r - 1'b1;
      end
      else
        ramp_acc_r <= ramp_sum_w;
    end
  end

  // Microstep pulses: |v| per base tick against 2^(pulse_div+16)
  logic [29:0] vel_acc_r;
  logic [7:0]  ustep_cnt_r;
  wire  [29:0] vel_thr_w = pow2(int'(pdiv_r) + rsr_pkg::VEL_FRAC_LOG2);
  wire  [29:0] vel_sum_w = vel_acc_r + 30'(mag(cur_v_r));
  wire         step_w    = tick_r && (vel_sum_w >= vel_thr_w);
  wire  [8:0]  res_mask_w = 9'(pow2(int'(res_r))) - 9'h001;
  wire  [POS_W-1:0] pos_step_w = !step_w ? pos_r :
                                 (cur_v_r < 0) ? pos_r - 1'b1 : pos_r + 1'b1;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      vel_acc_r   <= '0;
      ustep_cnt_r <= 8'h00;
      step_o      <= 1'b0;
      fullstep_o  <= 1'b0;
      dir_o       <= 1'b0;
    end
    else
    begin
      if (tick_r)
        vel_acc_r <= step_w ? vel_sum_w - vel_thr_w : vel_sum_w;
      if (step_w)
        ustep_cnt_r <= ustep_cnt_r + 8'h01;
      step_o     <= step_w;
      fullstep_o <= step_w && ((ustep_cnt_r & res_mask_w[7:0]) == res_mask_w[7:0]);
      dir_o      <= (cur_v_r > 0) ? 1'b1 : ((cur_v_r < 0) ? 1'b0 : dir_o);
    end
  end

  // Reference search sequencer
  logic [1:0]       fin_sel_r;    // 0 left, 1 right, 2 home
  logic             leg1_r, through_r, bounce_r;
  logic [POS_W-1:0] first_pos_r, hit_pos_r;

  wire home_w  = sw_q_r.home ^ home_inv_w;
  wire fin_sw_w = (fin_sel_r == 2'd0) ? sw_q_r.left :
                  (fin_sel_r == 2'd1) ? sw_q_r.right : home_w;
  // The first leg goes for the opposite end switch
  wire leg1_sw_w = (fin_sel_r == 2'd0) ? sw_q_r.right : sw_q_r.left;
  wire end_ahead_w = seek_pos_r ? sw_q_r.right : sw_q_r.left;
  wire [POS_W:0]    mid_sum_w = {hit_pos_r[POS_W-1], hit_pos_r} + {pos_r[POS_W-1], pos_r};
  wire [POS_W-1:0]  mid_w  = mid_sum_w[POS_W:1];
  wire [POS_W-1:0]  span_w = first_pos_r - mid_w;
  wire [POS_W-1:0]  span_abs_w = span_w[POS_W-1] ? -span_w : span_w;
  wire cal_done_w = in_cal_w && !fin_sw_w;
  wire ev_done_w  = cal_done_w;
  wire ev_abort_w = (cmd_stop && !idle_w) || (cmd_start && idle_w && !mode_ok_w);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      state_r     <= rsr_pkg::RS_IDLE;
      fin_sel_r   <= 2'd0;
      leg1_r      <= 1'b0;
      through_r   <= 1'b0;
      bounce_r    <= 1'b0;
      seek_pos_r  <= 1'b0;
      cal_pos_r   <= 1'b0;
      first_pos_r <= '0;
      hit_pos_r   <= '0;
      pos_r       <= '0;
      dist_r      <= '0;
    end
    else
    begin
      pos_r <= pos_step_w;
      if (cmd_stop)
        state_r <= rsr_pkg::RS_IDLE;
      else
        case (state_r)
          rsr_pkg::RS_IDLE:
            if (start_go)
            begin
              leg1_r    <= (base_w == 6'd2) || (base_w == 6'd3);
              through_r <= (base_w >= 6'd3);
              bounce_r  <= (base_w == 6'd5) || (base_w == 6'd6);
              if (base_w >= 6'd5)
              begin
                fin_sel_r  <= 2'd2;
                seek_pos_r <= (base_w == 6'd6) || (base_w == 6'd7);
              end
              else
              begin
                fin_sel_r  <= swap_w ? 2'd1 : 2'd0;
                // Left is the negative end; the first leg runs the other way
                seek_pos_r <= swap_w ^ ((base_w == 6'd2) || (base_w == 6'd3));
              end
              state_r <= ((base_w == 6'd2) || (base_w == 6'd3)) ? rsr_pkg::RS_LEG1
                                                                : rsr_pkg::RS_SEEK;
            end
          rsr_pkg::RS_LEG1:
            if (leg1_sw_w)
            begin
              first_pos_r <= pos_r;
              seek_pos_r  <= ~seek_pos_r;
              state_r     <= rsr_pkg::RS_SEEK;
            end
          rsr_pkg::RS_SEEK:
            if (fin_sw_w)
            begin
              hit_pos_r <= pos_r;
              // Edge modes back off the switch, middle modes pass through it
              cal_pos_r <= through_r ? seek_pos_r : ~seek_pos_r;
              state_r   <= rsr_pkg::RS_CAL;
            end
            else if (bounce_r && end_ahead_w)
              seek_pos_r <= ~seek_pos_r;
          rsr_pkg::RS_CAL:
            if (cal_done_w)
            begin
              pos_r   <= pos_step_w - mid_w;
              if (leg1_r)
                dist_r <= span_abs_w;
              state_r <= rsr_pkg::RS_IDLE;
            end
          default:
            state_r <= rsr_pkg::RS_IDLE;
        endcase
    end
  end

  // Interrupts: sticky, write one to clear, a new event wins over the clear
  logic autostop_q_r;
  wire  [rsr_pkg::IRQ_W-1:0] ev_w = {cmd_bad, autostop_w & ~autostop_q_r, ev_abort_w, ev_done_w};
  wire  [rsr_pkg::IRQ_W-1:0] clr_w = wr_istat ? pwdata_i[rsr_pkg::IRQ_W-1:0] : '0;
  wire  [rsr_pkg::IRQ_W-1:0] stat_nxt = (irq_stat_r & ~clr_w) | ev_w;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      irq_stat_r   <= '0;
      autostop_q_r <= 1'b0;
      irq_o        <= 1'b0;
      busy_o       <= 1'b0;
    end
    else
    begin
      irq_stat_r   <= stat_nxt;
      autostop_q_r <= autostop_w;
      irq_o        <= |(irq_stat_r & irq_mask_r);
      busy_o       <= !idle_w;
    end
  end

endmodule

// >>> rsr_pkg.sv
package rsr_pkg;

  // APB register map, byte addresses
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFF_CMD       = 12'h000;
  localparam logic [11:0] OFF_MODE      = 12'h004;
  localparam logic [11:0] OFF_SRCH_SPD  = 12'h008;
  localparam logic [11:0] OFF_CAL_SPD   = 12'h00C;
  localparam logic [11:0] OFF_DIVIDERS  = 12'h010;
  localparam logic [11:0] OFF_VELOCITY  = 12'h014;
  localparam logic [11:0] OFF_ACCEL     = 12'h018;
  localparam logic [11:0] OFF_STATUS    = 12'h01C;
  localparam logic [11:0] OFF_POSITION  = 12'h020;
  localparam logic [11:0] OFF_DISTANCE  = 12'h024;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h028;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h02C;

  // Field positions
  localparam int DIV_PULSE_LSB = 0;
  localparam int DIV_RAMP_LSB  = 4;
  localparam int DIV_RES_LSB   = 8;
  localparam int DIV_STOPL_BIT = 12;
  localparam int DIV_STOPR_BIT = 13;
  localparam int CMD_TYPE_LSB  = 8;
  localparam int IRQ_W         = 4;

  // Command encodings
  localparam logic [7:0] OPC_REF_SEARCH = 8'h0D;
  localparam logic [1:0] CMD_START      = 2'h0;
  localparam logic [1:0] CMD_STOP       = 2'h1;
  localparam logic [1:0] CMD_QUERY      = 2'h2;

  // Limits and values after reset
  localparam logic [3:0]  PULSE_DIV_MAX = 4'hD;
  localparam logic [3:0]  USTEP_RES_MAX = 4'h8;
  localparam logic [7:0]  MODE_RST      = 8'h01;
  localparam logic [10:0] SRCH_SPD_RST  = 11'h064;
  localparam logic [10:0] CAL_SPD_RST   = 11'h00A;
  localparam logic [3:0]  PULSE_DIV_RST = 4'h3;
  localparam logic [3:0]  RAMP_DIV_RST  = 4'h7;
  localparam logic [3:0]  USTEP_RES_RST = 4'h8;
  localparam logic [10:0] ACCEL_RST     = 11'h064;
  localparam int          VEL_FRAC_LOG2 = 16;
  localparam int          RAMP_LOG2     = 13;

  // Fractional divider for the 16 MHz pulse-base tick
  localparam int          CLK_HZ        = 125_000_000;
  localparam int          PULSE_BASE_HZ = 16_000_000;
  localparam logic [7:0]  TICK_NUM      = 8'(PULSE_BASE_HZ / 1_000_000);
  localparam logic [7:0]  TICK_DEN      = 8'(CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_LEG1 = 2'b01,
    RS_SEEK = 2'b10,
    RS_CAL  = 2'b11
  } rsr_state_e;

  typedef struct packed {
    logic home;
    logic right;
    logic left;
  } rsr_sw_s;

endpackage

// >>> rsr_core_monitor.sv
`timescale 1ns/100ps
module rsr_core_monitor
  (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rstn_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic        pslverr_o,
    // Motion
    input wire logic        step_o,
    input wire logic        fullstep_o,
    input wire logic        busy_o
  );
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  logic [3:0] start_h_r;
  wire        start_w;
  wire        bad_w;
  assign start_w = pready_o && pwrite_i && paddr_i == rsr_pkg::OFF_CMD
                   && pwdata_i[7:0] == rsr_pkg::OPC_REF_SEARCH;
  assign bad_w = paddr_i > rsr_pkg::OFF_IRQ_MASK || paddr_i[1:0] != 2'h0;
  // Busy may only rise a few cycles after a start write
  always_ff @(posedge ref_clk_i)
    start_h_r <= rstn_i ? {start_h_r[2:0], start_w} : 4'h0;

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence

  property p_answer;
    s_setup ##1 s_access |=> pready_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("ready missing after one wait state");
  property p_rdy_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_rdy_cause;
    pready_o |-> $past(psel_i && penable_i);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access");
  property p_rd_zero;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside ready");
  property p_err;
    pready_o |-> pslverr_o == bad_w;
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_err_only;
    pslverr_o |-> pready_o;
  endproperty
  a_err_only: assert property (p_err_only) else $error("error flag without ready");
  property p_step_gap;
    step_o |=> !step_o [*6];
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("steps faster than base tick");
  property p_full;
    fullstep_o |-> step_o;
  endproperty
  a_full: assert property (p_full) else $error("full step without microstep");
  property p_busy_cause;
    $rose(busy_o) |-> |start_h_r;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
endmodule

bind rsr_core rsr_core_monitor u_mon (.ref_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .step_o, .fullstep_o, .busy_o);

// >>> rsr_stage.sv
`timescale 1ns/100ps
// Linear stage: switches are short windows, so creeping through one always ends
module rsr_stage
  (
    // Motion in
    input  wire logic       ref_clk_i,
    input  wire logic       step_i,
    input  wire logic       dir_i,
    // Switches out
    output rsr_pkg::rsr_sw_s sw_o
  );
  int pos_r = 0;
  always_ff @(posedge ref_clk_i)
    if (step_i) pos_r <= dir_i ? pos_r + 1 : pos_r - 1;
  assign sw_o.left  = pos_r <= -3 && pos_r >= -5;
  assign sw_o.right = pos_r >= 3 && pos_r <= 5;
  assign sw_o.home  = pos_r == 0;
endmodule

// >>> rsr_core_test.sv
`timescale 1ns/100ps
module rsr_core_test;
  typedef struct packed {
    logic        w;
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] m;
    logic [31:0] x;
    logic        e;
  } rsr_row_s;
  logic             ref_clk_i = 1'b0;
  logic             rstn_i    = 1'b0;
  logic             psel_i    = 1'b0;
  logic             penable_i = 1'b0;
  logic             pwrite_i  = 1'b0;
  logic [11:0]      paddr_i   = 12'h000;
  logic [31:0]      pwdata_i  = 32'h0;
  logic             pready_o, pslverr_o, step_o, dir_o, fullstep_o, busy_o, irq_o, er;
  logic [31:0]      prdata_o, rd;
  logic [7:0]       md, dr, lo, hi;
  rsr_pkg::rsr_sw_s sw_i;
  int               errors = 0, comparisons = 0, cyc = 0, n, f;
  rsr_row_s rows[17] = '{
    '{1'b0, 12'h0, 32'h0, 12'h004, 32'hFFFFFFFF, 32'h01, 1'b0},
    '{1'b0, 12'h0, 32'h0, 12'h008, 32'hFFFFFFFF, 32'h64, 1'b0},
    '{1'b0, 12'h0, 32'h0, 12'h00C, 32'hFFFFFFFF, 32'h0A, 1'b0},
    '{1'b0, 12'h0, 32'h0, 12'h010, 32'hFFFFFFFF, 32'h873, 1'b0},
    '{1'b0, 12'h0, 32'h0, 12'h018, 32'hFFFFFFFF, 32'h64, 1'b0},
    '{1'b0, 12'h0, 32'h0, 12'h02C, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b0, 12'h0, 32'h0, 12'h020, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b0, 12'h0, 32'h0, 12'h01C, 32'h3, 32'h0, 1'b0},
    '{1'b1, 12'h018, 32'h7, 12'h01C, 32'h4, 32'h0, 1'b0},
    '{1'b1, 12'h018, 32'h8, 12'h01C, 32'h4, 32'h4, 1'b0},
    '{1'b1, 12'h010, 32'h803, 12'h010, 32'hFFFFFFFF, 32'h803, 1'b0},
    '{1'b1, 12'h018, 32'h200, 12'h01C, 32'h4, 32'h0, 1'b0},
    '{1'b1, 12'h018, 32'h1FF, 12'h01C, 32'h4, 32'h4, 1'b0},
    '{1'b1, 12'h010, 32'h3FFF, 12'h010, 32'hFFFFFFFF, 32'h38FD, 1'b0},
    '{1'b1, 12'h014, 32'h800, 12'h014, 32'hFFFFFFFF, 32'hFFFFF801, 1'b0},
    '{1'b1, 12'h020, 32'h1234, 12'h020, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b1, 12'h030, 32'h5, 12'h030, 32'hFFFFFFFF, 32'h0, 1'b1}};
  // Mode, first direction, distance window; order keeps the slider on the stage
  logic [31:0] srch[13] = '{32'h01000000, 32'h02010407, 32'h42000407, 32'h03010609,
    32'h44010000, 32'h43000609, 32'h04000000, 32'h41010000, 32'h06010000,
    32'h05000000, 32'h08000000, 32'h07010000, 32'h88000000};

  always #4 ref_clk_i = ~ref_clk_i;

  rsr_core dut (.ref_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .prdata_o, .pslverr_o, .sw_i, .step_o, .dir_o, .fullstep_o, .busy_o, .irq_o);
  rsr_stage u_stage (.ref_clk_i, .step_i(step_o), .dir_i(dir_o), .sw_o(sw_i));

  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_busy(input logic v, input int lim);
    n = 0;
    do @(posedge ref_clk_i); while (busy_o !== v && ++n < lim);
    chk("busy", v, busy_o);
  endtask

  task automatic count(input int c);
    n = 0;
    f = 0;
    repeat (c)
    begin
      @(posedge ref_clk_i);
      n += step_o;
      f += fullstep_o;
    end
  endtask

  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      errors++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    chk("busy", 0, busy_o);
    foreach (rows[i])
    begin
      if (rows[i].w) apb(1'b1, rows[i].wa, rows[i].wd);
      apb(1'b0, rows[i].ra, 32'h0);
      chk("reg", rows[i].x, rd & rows[i].m);
      chk("slverr", rows[i].e, er);
    end
    apb(1'b1, rsr_pkg::OFF_VELOCITY, 32'h0);
    apb(1'b1, rsr_pkg::OFF_SRCH_SPD, 32'h7FF);
    apb(1'b1, rsr_pkg::OFF_CAL_SPD, 32'h7FF);
    apb(1'b1, rsr_pkg::OFF_ACCEL, 32'h0);
    // Both auto-stop enables set; searches must still run through the end switches
    apb(1'b1, rsr_pkg::OFF_DIVIDERS, 32'h3000);
    apb(1'b1, rsr_pkg::OFF_IRQ_MASK, 32'h1);
    foreach (srch[i])
    begin
      {md, dr, lo, hi} = srch[i];
      apb(1'b1, rsr_pkg::OFF_MODE, {24'h0, md});
      apb(1'b1, rsr_pkg::OFF_CMD, 32'h0D);
      n = 0;
      do @(posedge ref_clk_i); while (step_o !== 1'b1 && ++n < 2000);
      chk("first_dir", dr[0], dir_o);
      chk("busy", 1, busy_o);
      wait_busy(1'b0, 9000);
      repeat (3) @(posedge ref_clk_i);
      chk("irq", 1, irq_o);
      apb(1'b0, rsr_pkg::OFF_IRQ_STAT, 32'h0);
      chk("done", 1, rd[0]);
      apb(1'b0, rsr_pkg::OFF_POSITION, 32'h0);
      chk("zero", 1, $signed(rd) >= -3 && $signed(rd) <= 3);
      if (hi != 8'h00)
      begin
        apb(1'b0, rsr_pkg::OFF_DISTANCE, 32'h0);
        chk("distance", 1, rd >= lo && rd <= hi);
      end
      apb(1'b1, rsr_pkg::OFF_IRQ_STAT, 32'hF);
      repeat (3) @(posedge ref_clk_i);
      chk("irq_clear", 0, irq_o);
    end
    // Bad mode, bad opcode and a query: no run, events latched but masked
    apb(1'b1, rsr_pkg::OFF_IRQ_MASK, 32'h0);
    apb(1'b1, rsr_pkg::OFF_MODE, 32'h09);
    apb(1'b1, rsr_pkg::OFF_CMD, 32'h0D);
    apb(1'b1, rsr_pkg::OFF_CMD, 32'h05);
    apb(1'b1, rsr_pkg::OFF_CMD, 32'h20D);
    repeat (3) @(posedge ref_clk_i);
    chk("busy", 0, busy_o);
    chk("irq_masked", 0, irq_o);
    apb(1'b0, rsr_pkg::OFF_IRQ_STAT, 32'h0);
    chk("events", 32'hA, rd & 32'hF);
    apb(1'b1, rsr_pkg::OFF_MODE, 32'h07);
    apb(1'b1, rsr_pkg::OFF_CMD, 32'h0D);
    repeat (20) @(posedge ref_clk_i);
    chk("busy", 1, busy_o);
    apb(1'b1, rsr_pkg::OFF_CMD, 32'h10D);
    wait_busy(1'b0, 10);
    apb(1'b1, rsr_pkg::OFF_IRQ_STAT, 32'hF);
    // Velocity mode: right auto-stop halts the slider at the right switch
    apb(1'b1, rsr_pkg::OFF_DIVIDERS, 32'h2200);
    apb(1'b1, rsr_pkg::OFF_VELOCITY, 32'h7FF);
    count(3000);
    count(1000);
    chk("stopped", 0, n);
    apb(1'b0, rsr_pkg::OFF_IRQ_STAT, 32'h0);
    chk("autostop", 1, rd[2]);
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, rsr_pkg::OFF_DIVIDERS, 32'h200 | p);
      count(400);
      count(8000);
      chk("rate", 1, n >= (32 >> p) - 1 && n <= (32 >> p) + 1);
      chk("fullstep", 1, f * 4 >= n - 4 && f * 4 <= n + 4);
    end
    // Ramp down from 2047: about 512 base ticks at 2047/2^13 units each
    apb(1'b1, rsr_pkg::OFF_ACCEL, 32'h7FF);
    apb(1'b1, rsr_pkg::OFF_VELOCITY, 32'h0);
    repeat (4000) @(posedge ref_clk_i);
    apb(1'b0, rsr_pkg::OFF_STATUS, 32'h0);
    chk("ramp", 1, rd[27:16] >= 12'd1917 && rd[27:16] <= 12'd1921);
    print_verdict();
  end
endmodule
